//--- dv/odl_host_model.sv
// Host model of the three-wire link: select, link clock and serial data.
// Assumes the loader samples data on the link clock rise while selected.
`timescale 1ns/1ps
module odl_host_model (
   output logic selectLow,
   output logic linkClk,
   output logic serialInPin
);
   // Clock rests high between frames, so each frame ends on a high level
   initial begin
      selectLow   = 1'b1;
      linkClk     = 1'b1;
      serialInPin = 1'b0;
   end

   // One 15 ns period; data moves on the fall, well away from the rise
   task automatic shiftBit(input logic b);
      linkClk     = 1'b0;
      serialInPin = b;
      #7.5;
      linkClk     = 1'b1; // Clean single edge, no bounce
      #7.5;
   endtask : shiftBit

   // Select high gap of 80 ns covers the loader's 60 ns sampling need
   task automatic openFrame();
      #80;
      selectLow = 1'b0;
      #10;
   endtask : openFrame

   // Clock held high at the select rise, data released to a changed level
   task automatic closeFrame();
      #7.5;
      selectLow   = 1'b1;
      serialInPin = ~serialInPin;
   endtask : closeFrame

   // Address then code, high bit first
   task automatic send11(input logic [10:0] w);
      openFrame();
      for (int i = 10; i >= 0; i--) shiftBit(w[i]);
      closeFrame();
   endtask : send11

   // Sixteen bits, as a byte-wide host would send them
   task automatic send16(input logic [15:0] w);
      openFrame();
      for (int i = 15; i >= 0; i--) shiftBit(w[i]);
      closeFrame();
   endtask : send16

   // Link clock edges while deselected, which must change nothing
   task automatic strayClocks();
      for (int i = 0; i < 11; i++) shiftBit(i[0]);
   endtask : strayClocks
endmodule : odl_host_model

//--- dv/test_octal_dac_serial_loader.sv
// Self-checking bench of the octal converter serial loader.
// Assumes the host model drives the link; clk is made here at 50 MHz.
`timescale 1ns/1ps
module test_octal_dac_serial_loader;
   logic            clk;
   logic            rst_n;
   logic            linkClk;
   logic            selectLow;
   logic            serialInPin;
   logic            midscaleResetLow;
   logic            powerDownLow;
   logic [7:0][7:0] channelOutput;
   logic [7:0]      channelOutputOeLow;
   logic [3:0]      lastChannel;
   logic            loadDone;
   logic [7:0]      expCode [8];
   logic            seen;
   int              num_errors;
   int              total_checks;
   localparam logic [2:0] ORDER [8] = '{5, 0, 7, 2, 6, 1, 4, 3};

   odl_host_model u_host (.selectLow(selectLow), .linkClk(linkClk),
      .serialInPin(serialInPin));
   odl_loader u_dut (.clk(clk), .rst_n(rst_n), .linkClk(linkClk),
      .selectLow(selectLow), .serialInPin(serialInPin),
      .midscaleResetLow(midscaleResetLow), .powerDownLow(powerDownLow),
      .channelOutput(channelOutput),
      .channelOutputOeLow(channelOutputOeLow),
      .lastChannel(lastChannel), .loadDone(loadDone));

   // System clock, 20 ns period
   always #10 clk = ~clk;

   task automatic cmpVal(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmpVal

   task automatic cmpCodes();
      for (int i = 0; i < 8; i++) cmpVal(channelOutput[i], expCode[i]);
   endtask : cmpCodes

   // Bounded wait; a load answers 3 to 4 edges after select rises
   task automatic waitLoad();
      seen = 1'b0;
      for (int i = 0; i < 12 && !seen; i++) begin
         @(posedge clk);
         #1;
         if (loadDone === 1'b1) seen = 1'b1;
      end
   endtask : waitLoad

   task automatic checkLoad(input logic [2:0] a, input logic [7:0] c);
      waitLoad();
      expCode[a] = c;
      cmpVal({7'h00, seen}, 8'h01);
      cmpVal({4'h0, lastChannel}, {5'h00, a} + 8'h01);
      cmpCodes();
   endtask : checkLoad

   task automatic loadWord(input logic [2:0] a, input logic [7:0] c);
      u_host.send11({a, c});
      checkLoad(a, c);
   endtask : loadWord

   task automatic testReset();
      cmpCodes();
      cmpVal({4'h0, lastChannel}, 8'h00);
      repeat (4) @(posedge clk);
      #1;
      cmpVal(channelOutputOeLow, 8'h00);
      $display("test reset done");
   endtask : testReset

   // Scrambled order, then the code boundaries at both end channels
   task automatic testChannels();
      for (int i = 0; i < 8; i++) loadWord(ORDER[i], {ORDER[i], 5'h15});
      loadWord(3'h0, 8'h00);
      loadWord(3'h7, 8'hFF);
      $display("test channels done");
   endtask : testChannels

   // Five leading ones would point at channel 8 if the front were kept
   task automatic testLongAndStray();
      u_host.send16(16'hFAC3);
      checkLoad(3'h2, 8'hC3);
      u_host.strayClocks();
      waitLoad();
      cmpVal({7'h00, seen}, 8'h00);
      cmpCodes();
      $display("test long and stray done");
   endtask : testLongAndStray

   // Loads still land during shutdown and show once outputs return
   task automatic testShutdown();
      @(posedge clk) powerDownLow <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      cmpVal(channelOutputOeLow, 8'hFF);
      loadWord(3'h4, 8'h5A);
      @(posedge clk) powerDownLow <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      cmpVal(channelOutputOeLow, 8'h00);
      cmpCodes();
      $display("test shutdown done");
   endtask : testShutdown

   // Asynchronous: checked 2 ns after the pin falls, before any clk edge
   task automatic testMidscale();
      @(posedge clk) midscaleResetLow <= 1'b0;
      #2;
      for (int i = 0; i < 8; i++) expCode[i] = 8'h80;
      cmpCodes();
      // Pin held three clk periods to meet the minimum reset pulse width
      repeat (3) @(posedge clk);
      midscaleResetLow <= 1'b1;
      loadWord(3'h1, 8'h3C);
      $display("test midscale done");
   endtask : testMidscale

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   // Whole run takes about 5 us; the watchdog allows far more
   initial begin
      #300000;
      num_errors++;
      $display("ERROR %0t: watchdog expired", $time);
      tally_and_finish();
   end

   // Main sequence: reset held for two clk edges, then every test
   initial begin
      clk              = 1'b0;
      rst_n            = 1'b0;
      midscaleResetLow = 1'b1;
      powerDownLow     = 1'b1;
      num_errors       = 0;
      total_checks     = 0;
      for (int i = 0; i < 8; i++) expCode[i] = 8'h80;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      testReset();
      testChannels();
      testLongAndStray();
      testShutdown();
      testMidscale();
      tally_and_finish();
   end
endmodule : test_octal_dac_serial_loader

//--- hdl/odl_link_if.sv
// Link-side carrier between the loader core and its serial shifter.
// Assumes the shifter runs on the link clock and the core on clk.
`timescale 1ns/1ps
interface odl_link_if;
   logic              selectLow;
   logic              serialIn;
   odl_pkg::odl_word_t word;

   modport shifter (input selectLow, input serialIn, output word);
   modport core    (output selectLow, output serialIn, input word);
endinterface : odl_link_if

//--- hdl/odl_loader.sv
// Serial load logic of an eight channel 8-bit voltage output converter.
// Assumes clk at 50 MHz, a free or stopped link clock up to 33 MHz, and
// select held high for at least three clk periods between frames.
`timescale 1ns/1ps
module odl_loader (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                linkClk,
   input  wire logic                selectLow,
   input  wire logic                serialInPin,
   input  wire logic                midscaleResetLow,
   input  wire logic                powerDownLow,
   output logic [7:0][7:0]          channelOutput,
   output logic [7:0]               channelOutputOeLow,
   output logic [3:0]               lastChannel,
   output logic                     loadDone
);

   // Link clock logic lives in the shifter; the core samples its word
   odl_link_if link ();

   assign link.selectLow = selectLow;
   assign link.serialIn  = serialInPin;

   // Link rate up to the limit is handled by the shifter on its own
   // clock; the core never looks at link clock edges
   odl_shifter u_shifter (
      .linkClk (linkClk),
      .link    (link)
   );

   typedef struct packed {
      logic [odl_pkg::SYNC_STAGES-1:0] selSync;
      logic [odl_pkg::SYNC_STAGES-1:0] pdSync;
      logic                            selPrev;
      odl_pkg::odl_codes_t             codes;
      logic [7:0]                      oeLow;
      logic [3:0]                      lastChan;
      logic                            loaded;
   } odl_core_s;

   odl_core_s st_r;
   odl_core_s st_nxt;

   // Constant image used by both resets; every code at half scale
   localparam odl_core_s RESET_STATE = '{
      selSync  : '1,
      pdSync   : '1,
      selPrev  : 1'b1,
      codes    : {odl_pkg::CHANNELS{odl_pkg::MIDSCALE_CODE}},
      oeLow    : 8'hFF,
      lastChan : 4'h0,
      loaded   : 1'b0
   };

   // Combinational decode of the sampled select edge
   logic                            frameEnd;
   logic [odl_pkg::ADDR_BITS-1:0]   addrField;
   logic [odl_pkg::CODE_BITS-1:0]   codeField;

   // The word crosses without extra flops: it is frozen while select is
   // high, and the two stage select sampler delays the look at it by at
   // least two clk periods, well past any shifter settling
   assign frameEnd  = st_r.selSync[odl_pkg::SYNC_STAGES-1] & ~st_r.selPrev;
   assign addrField =
      link.word[odl_pkg::ADDR_MSB:odl_pkg::ADDR_LSB];
   assign codeField =
      link.word[odl_pkg::CODE_MSB:odl_pkg::CODE_LSB];

   // Next state: samplers, channel load, output enables
   always_comb begin
      st_nxt = st_r;
      // Two stage samplers; only the last stage is read by logic
      st_nxt.selSync = {st_r.selSync[0], selectLow};
      st_nxt.pdSync  = {st_r.pdSync[0], powerDownLow};
      st_nxt.selPrev = st_r.selSync[odl_pkg::SYNC_STAGES-1];
      st_nxt.loaded  = 1'b0;
      // One channel changes per frame end, the rest keep their codes
      if (frameEnd) begin
         st_nxt.codes[addrField] = codeField;
         st_nxt.lastChan = {1'b0, addrField}
                         + odl_pkg::CHANNEL_BASE;
         st_nxt.loaded   = 1'b1;
      end
      // Shutdown only floats the pins; codes are left alone
      st_nxt.oeLow = {odl_pkg::CHANNELS{
                        ~st_r.pdSync[odl_pkg::SYNC_STAGES-1]}};
   end

   // Midscale pin acts at once, without the clock; power-on reset is the
   // synchronous system reset and gives the same image
   always_ff @(posedge clk or negedge midscaleResetLow) begin
      if (!midscaleResetLow) begin
         st_r <= RESET_STATE;
      end else if (!rst_n) begin
         st_r <= RESET_STATE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign channelOutput      = st_r.codes;
   assign channelOutputOeLow = st_r.oeLow;
   assign lastChannel        = st_r.lastChan;
   assign loadDone           = st_r.loaded;

   // Checks on the clk domain; both resets disable them, except a_reset_mid, which only the midscale pin disables

   a_load_target: assert property (
      @(posedge clk) disable iff (!rst_n || !midscaleResetLow)
      frameEnd |=> channelOutput[$past(addrField)] == $past(codeField))
      else $error("addressed channel did not take the code");

   a_chan_number: assert property (
      @(posedge clk) disable iff (!rst_n || !midscaleResetLow)
      frameEnd |=> lastChannel == {1'b0, $past(addrField)} + 4'h1)
      else $error("channel number is not address plus one");

   a_load_single: assert property (
      @(posedge clk) disable iff (!rst_n || !midscaleResetLow)
      loadDone |=> !loadDone)
      else $error("one frame end produced two loads");

   a_done_cause: assert property (
      @(posedge clk) disable iff (!rst_n || !midscaleResetLow)
      $rose(loadDone) |-> $past(frameEnd))
      else $error("load flagged without a frame end");

   a_idle_hold: assert property (
      @(posedge clk) disable iff (!rst_n || !midscaleResetLow)
      !frameEnd |=> $stable(channelOutput))
      else $error("channel codes moved with no frame end");

   // Each channel not addressed keeps its code across a load
   genvar gi;
   generate
      for (gi = 0; gi < odl_pkg::CHANNELS; gi++) begin : g_chan
         a_others_keep: assert property (
            @(posedge clk) disable iff (!rst_n || !midscaleResetLow)
            (frameEnd && addrField != gi) |=> $stable(channelOutput[gi]))
            else $error("unaddressed channel changed");
      end
   endgenerate

   a_reset_mid: assert property (
      @(posedge clk) disable iff (!midscaleResetLow)
      !rst_n |=> channelOutput == {8{8'h80}} && channelOutputOeLow == 8'hFF)
      else $error("reset did not give midscale codes");

   a_frame_latency: assert property (
      @(posedge clk) disable iff (!rst_n || !midscaleResetLow)
      (!selectLow ##1 selectLow [*3]) |-> ##[0:1] frameEnd)
      else $error("frame end not seen within the sampler delay");

   a_float_down: assert property (
      @(posedge clk) disable iff (!rst_n || !midscaleResetLow)
      !powerDownLow [*3] |=> channelOutputOeLow == 8'hFF)
      else $error("outputs driven during shutdown");

   a_resume_drive: assert property (
      @(posedge clk) disable iff (!rst_n || !midscaleResetLow)
      powerDownLow [*3] |=> channelOutputOeLow == 8'h00)
      else $error("outputs not driven after shutdown ended");

   a_down_keeps: assert property (
      @(posedge clk) disable iff (!rst_n || !midscaleResetLow)
      (channelOutputOeLow == 8'hFF && !frameEnd) |=> $stable(channelOutput))
      else $error("shutdown disturbed a held code");

endmodule : odl_loader

//--- hdl/odl_pkg.sv
// Constants shared by the octal converter serial loader.
// Assumes a 50 MHz system clock and a link clock of up to 33 MHz.
package odl_pkg;

   // Serial word layout: address above code, both sent high bit first
   localparam int WORD_BITS  = 11;
   localparam int ADDR_MSB   = 10;
   localparam int ADDR_LSB   = 8;
   localparam int CODE_MSB   = 7;
   localparam int CODE_LSB   = 0;
   localparam int ADDR_BITS  = 3;
   localparam int CODE_BITS  = 8;
   localparam int CHANNELS   = 8;

   // Channel register value after either reset: half of full scale
   localparam logic [7:0] MIDSCALE_CODE = 8'h80;

   // Offset between the address field and the channel number
   localparam logic [3:0] CHANNEL_BASE = 4'h1;

   // Clock figures
   localparam int SYS_CLK_HZ    = 50_000_000;
   localparam int LINK_MAX_HZ   = 33_000_000;
   localparam int SYNC_STAGES   = 2;
   // Select must stay high this long so the sampler sees every frame end
   localparam int SEL_HIGH_NS   = 60;
   localparam int SEL_HIGH_CYC  =
      (SEL_HIGH_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

   typedef logic [WORD_BITS-1:0] odl_word_t;
   typedef logic [CHANNELS-1:0][CODE_BITS-1:0] odl_codes_t;

endpackage : odl_pkg

//--- hdl/odl_shifter.sv
// Serial shift register clocked by the link's own clock.
// Assumes select and data meet setup and hold to the link clock edge.
`timescale 1ns/1ps
module odl_shifter (
   input  wire logic   linkClk,
   odl_link_if.shifter link
);

   typedef struct packed {
      odl_pkg::odl_word_t shift;
   } odl_shift_s;

   odl_shift_s st_r;
   odl_shift_s st_nxt;

   // Shift toward the top while selected; hold otherwise
   // No reset here: the link clock may be stopped while reset is applied
   always_comb begin
      st_nxt = st_r;
      if (!link.selectLow) begin
         st_nxt.shift = {st_r.shift[odl_pkg::WORD_BITS-2:0],
                         link.serialIn};
      end
   end

   always_ff @(posedge linkClk) begin
      st_r <= st_nxt;
   end

   // Word stays frozen while select is high, so the core may sample it
   assign link.word = st_r.shift;

   // The register has no reset, so only bit 0 is known from the first
   // edge on; the upper bits are checked once ten selected edges filled them
   a_shift_in: assert property (
      @(posedge linkClk) !link.selectLow |=>
         st_r.shift[0] == $past(link.serialIn))
      else $error("shift register did not take the serial bit");

   a_shift_up: assert property (
      @(posedge linkClk)
      (!link.selectLow [*8] ##1 !link.selectLow ##1 !link.selectLow) |=>
         st_r.shift[10:1] == $past(st_r.shift[9:0]))
      else $error("shift register did not move toward its top");

   a_shift_hold: assert property (
      @(posedge linkClk) link.selectLow |=> $stable(st_r.shift))
      else $error("shift register moved while deselected");

endmodule : odl_shifter
